// >>> hw/boot_option_loader.sv
// Boot option loader: option latch, boot select, watchdog guard, readout
//
// Functional notes
// - Firmware cannot change option settings
// - Erased options all read disabled
// - Seven programming region starts, eighth disables
// - Programming region ends at last flash address
// - Data region size in half-K steps
// - Data region ends below programming region
// - Power-up boots programming region if selected
// - Both boot selects off means application boot
// - Second option boots programming region on pin
// - Second option off defers to first
// - Scramble option scrambles writer readout
// - Lock option blocks code readout
// - Protected in application: only clear writable
// - Protected in programming: clear and prescaler
// - Unprotected watchdog control fully writable
// - Auto-enable presets watchdog at power-up
// - No auto-enable leaves watchdog untouched
// - Application boot starts at address zero
`timescale 1ns/10ps
`default_nettype none

module boot_option_loader
    import boot_option_pkg::*;
#(
    parameter logic [7:0] SCRAMBLE_KEY = 8'h5a
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Non-volatile option storage
    output logic nv_read_en,
    input wire logic [17:0] nv_option,
    // Pins
    input wire logic ext_reset_pin,
    input wire logic prog_mode_pin,
    // CPU side
    input wire logic cpu_in_isp,
    output logic cpu_reset_n,
    output logic boot_from_isp,
    output logic [13:0] boot_addr,
    output region_type region,
    // Watchdog
    output logic watchdog_enable_bit,
    output logic watchdog_idle_count_bit,
    output logic [2:0] watchdog_prescaler_field,
    output logic watchdog_clear_bit,
    // Writer readout path
    input wire logic flash_rvalid,
    input wire logic [13:0] flash_raddr,
    input wire logic [7:0] flash_rdata,
    output logic prog_dvalid,
    output logic [7:0] prog_dout,
    output logic code_lock
);

    ////////////////////////////////////////////////////////////////////////
    // Region arithmetic

    function automatic logic [13:0] isp_start_of(input logic [2:0] code);
        isp_start_of = 14'(ISP_BASE + 14'(code) * ISP_STEP);
    endfunction

    function automatic logic [14:0] iap_size_of(input logic [4:0] code);
        logic [4:0] pages;
        pages = 5'(IAP_OFF_CODE - code);
        iap_size_of = 15'({10'h000, pages} << PAGE_SHIFT);
    endfunction

    function automatic logic [7:0] scramble(input logic [7:0] data,
                                            input logic [13:0] addr);
        scramble = data ^ addr[7:0] ^ SCRAMBLE_KEY;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic ext_meta;
    logic ext_sync;
    logic prog_meta;
    logic prog_sync;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            prog_meta <= 1'b0;
            prog_sync <= 1'b0;
        end else if (clk_en) begin
            ext_meta <= ext_reset_pin;
            ext_sync <= ext_meta;
            prog_meta <= prog_mode_pin;
            prog_sync <= prog_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Option loader and boot selection

    loader_state_type state;
    loader_state_type next_state;
    logic [3:0] load_cnt;
    logic [3:0] next_load_cnt;
    option_type opts;
    option_type next_opts;
    logic power_up;
    logic next_power_up;
    logic next_cpu_reset_n;
    logic next_boot_from_isp;
    logic [13:0] next_boot_addr;
    region_type next_region;
    logic isp_on;
    logic [13:0] isp_start;
    logic [14:0] iap_top;
    logic [14:0] iap_size;
    logic boot_isp_pick;

    always_comb begin
        // Region map follows the latched word only, never firmware
        isp_on = (opts.isp_size != ISP_OFF_CODE);
        isp_start = isp_start_of(opts.isp_size);
        iap_top = isp_on ? {1'b0, isp_start} : FLASH_LIMIT;
        iap_size = iap_size_of(opts.iap_size);
        next_region.isp_on = isp_on;
        next_region.isp_start = isp_on ? isp_start : FLASH_END;
        next_region.iap_on = (opts.iap_size != IAP_OFF_CODE);
        next_region.iap_low = (iap_top > iap_size) ?
            14'(iap_top - iap_size) : 14'h0000;
        next_region.iap_high = 14'(iap_top - 15'h0001);
        // Power-up uses the first option; the pin may also use the second
        boot_isp_pick = isp_on && (power_up ?
            !opts.boot_select_option_n :
            (!opts.boot_select_option_n ||
             !opts.reset_boot_select_option_n));
        next_state = state;
        next_load_cnt = load_cnt;
        next_opts = opts;
        next_power_up = power_up;
        next_boot_from_isp = boot_from_isp;
        next_boot_addr = boot_addr;
        case (state)
            ST_LOAD: begin
                next_load_cnt = 4'(load_cnt + 4'h1);
                if (load_cnt == 4'(NV_READ_CYCLES - 1)) begin
                    next_opts = nv_option;
                    next_load_cnt = 4'h0;
                    next_state = ST_APPLY;
                end
            end
            ST_APPLY: begin
                next_boot_from_isp = boot_isp_pick;
                next_boot_addr = boot_isp_pick ?
                    isp_start : AP_ENTRY;
                next_state = ST_RUN;
            end
            ST_RUN: begin
                if (ext_sync) begin
                    next_power_up = 1'b0;
                    next_state = ST_EXT;
                end
            end
            ST_EXT: begin
                // Reload so a writer change is seen at the next pin reset
                if (!ext_sync) begin
                    next_state = ST_LOAD;
                end
            end
            default: begin
                next_state = ST_LOAD;
            end
        endcase
        next_cpu_reset_n = (next_state == ST_RUN);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_LOAD;
            load_cnt <= 4'h0;
            opts <= OPTION_ERASED;
            power_up <= 1'b1;
            cpu_reset_n <= 1'b0;
            boot_from_isp <= 1'b0;
            boot_addr <= AP_ENTRY;
            region <= '0;
        end else if (clk_en) begin
            state <= next_state;
            load_cnt <= next_load_cnt;
            opts <= next_opts;
            power_up <= next_power_up;
            cpu_reset_n <= next_cpu_reset_n;
            boot_from_isp <= next_boot_from_isp;
            boot_addr <= next_boot_addr;
            region <= next_region;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave and watchdog control register

    logic access;
    logic wr_fire;
    logic wdt_wr;
    logic [5:0] wdt;
    logic [5:0] next_wdt;
    logic [5:0] wdt_mask;
    logic apply_preset;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_clear;
    logic next_nv_read_en;
    logic mapped;

    always_comb begin
        access = psel && penable;
        wr_fire = access && pready && pwrite;
        wdt_wr = wr_fire && (paddr == OFS_WDT);
        apply_preset = (state == ST_APPLY) && power_up &&
            !opts.watchdog_auto_enable_option_n;
        if (opts.watchdog_write_protect_option_n) begin
            wdt_mask = WDT_MASK_ALL;
        end else if (cpu_in_isp) begin
            wdt_mask = WDT_MASK_CLEAR_PS;
        end else begin
            wdt_mask = WDT_MASK_CLEAR;
        end
        next_wdt = wdt;
        if (apply_preset) begin
            next_wdt[WDT_ENABLE_POS] = 1'b1;
            next_wdt[WDT_IDLE_POS] = opts.idle_count_preset;
            next_wdt[WDT_PS_LSB +: 3] = opts.prescaler_preset;
        end else if (wdt_wr) begin
            next_wdt = (wdt & ~wdt_mask) | (pwdata[5:0] & wdt_mask);
        end
        // The clear bit is a strobe, never stored
        next_wdt[WDT_CLEAR_POS] = 1'b0;
        next_clear = wdt_wr && pwdata[WDT_CLEAR_POS];
        // One wait state so read data can come straight from a flop
        next_pready = access && !pready;
        mapped = 1'b1;
        next_prdata = 32'h0000_0000;
        case (paddr)
            OFS_OPTION: next_prdata = {14'h0000, opts};
            OFS_BOOT: next_prdata = {26'h0000000, opts.lock_option_n,
                opts.scramble_option_n, power_up, cpu_reset_n,
                cpu_in_isp, boot_from_isp};
            OFS_ISP: next_prdata = {17'h00000, region.isp_on,
                region.isp_start};
            OFS_IAP_LOW: next_prdata = {17'h00000, region.iap_on,
                region.iap_low};
            OFS_IAP_HIGH: next_prdata = {18'h00000, region.iap_high};
            OFS_WDT: next_prdata = {26'h0000000, wdt};
            default: mapped = 1'b0;
        endcase
        next_pslverr = next_pready && !mapped;
        if (!next_pready) begin
            next_prdata = 32'h0000_0000;
        end
        next_nv_read_en = (next_state == ST_LOAD);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt <= WDT_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            watchdog_clear_bit <= 1'b0;
            nv_read_en <= 1'b0;
        end else if (clk_en) begin
            wdt <= next_wdt;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            watchdog_clear_bit <= next_clear;
            nv_read_en <= next_nv_read_en;
        end
    end

    assign watchdog_enable_bit = wdt[WDT_ENABLE_POS];
    assign watchdog_idle_count_bit = wdt[WDT_IDLE_POS];
    assign watchdog_prescaler_field = wdt[WDT_PS_LSB +: 3];

    ////////////////////////////////////////////////////////////////////////
    // Writer readout path; lock wins over scramble

    logic next_prog_dvalid;
    logic [7:0] next_prog_dout;

    always_comb begin
        next_prog_dvalid = flash_rvalid && prog_sync;
        if (!opts.lock_option_n) begin
            next_prog_dout = 8'h00;
        end else if (!opts.scramble_option_n) begin
            next_prog_dout = scramble(flash_rdata, flash_raddr);
        end else begin
            next_prog_dout = flash_rdata;
        end
        if (!next_prog_dvalid) begin
            next_prog_dout = 8'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_dvalid <= 1'b0;
            prog_dout <= 8'h00;
            code_lock <= 1'b0;
        end else if (clk_en) begin
            prog_dvalid <= next_prog_dvalid;
            prog_dout <= next_prog_dout;
            code_lock <= !opts.lock_option_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_cpu_held_load: assert property (
        (state == ST_LOAD || state == ST_APPLY) |-> !cpu_reset_n)
        else $error("cpu released before options were latched");

    chk_opts_stable_run: assert property (
        (state == ST_RUN) && $past(state == ST_RUN) |-> $stable(opts))
        else $error("option word changed while running");

    chk_ap_entry_zero: assert property (
        cpu_reset_n && !boot_from_isp |-> boot_addr == AP_ENTRY)
        else $error("application boot not at address zero");

    chk_boot_off_ap: assert property (
        (state == ST_APPLY) && clk_en && opts.boot_select_option_n &&
        opts.reset_boot_select_option_n |=> !boot_from_isp)
        else $error("boot select off but programming region chosen");

    chk_pin_boot_isp: assert property (
        (state == ST_APPLY) && clk_en && !power_up && isp_on &&
        !opts.reset_boot_select_option_n |=> boot_from_isp &&
        boot_addr == isp_start)
        else $error("pin reset missed programming region boot");

    chk_iap_top_bound: assert property (
        clk_en && presetn |=> region.iap_high == (region.isp_on ?
        14'(region.isp_start - 14'h0001) : FLASH_END))
        else $error("data region end misplaced");

    chk_wdt_guard_ap: assert property (
        wdt_wr && clk_en && !apply_preset && cpu_in_isp == 1'b0 &&
        !opts.watchdog_write_protect_option_n |=> $stable(wdt))
        else $error("protected watchdog control written from application");

    chk_wdt_guard_isp: assert property (
        wdt_wr && clk_en && !apply_preset && cpu_in_isp &&
        !opts.watchdog_write_protect_option_n |=>
        wdt[WDT_PS_LSB +: 3] == $past(pwdata[2:0]) &&
        wdt[5:3] == $past(wdt[5:3]))
        else $error("programming region watchdog write wrong");

    chk_wdt_free: assert property (
        wdt_wr && clk_en && !apply_preset &&
        opts.watchdog_write_protect_option_n |=>
        wdt == ($past(pwdata[5:0]) & ~WDT_MASK_CLEAR))
        else $error("unprotected watchdog write not stored");

    chk_auto_preset: assert property (
        apply_preset && clk_en |=> watchdog_enable_bit &&
        watchdog_idle_count_bit == $past(opts.idle_count_preset) &&
        watchdog_prescaler_field == $past(opts.prescaler_preset))
        else $error("watchdog presets not applied at power-up");

    chk_lock_blocks: assert property (
        code_lock |-> prog_dout == 8'h00)
        else $error("locked code leaked on readout");

endmodule

`default_nettype wire

// >>> hw/boot_option_pkg.sv
// Constants, field layouts and carrier types of the boot option loader
package boot_option_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses)
    localparam logic [11:0] OFS_OPTION = 12'h000;
    localparam logic [11:0] OFS_BOOT = 12'h004;
    localparam logic [11:0] OFS_ISP = 12'h008;
    localparam logic [11:0] OFS_IAP_LOW = 12'h00c;
    localparam logic [11:0] OFS_IAP_HIGH = 12'h010;
    localparam logic [11:0] OFS_WDT = 12'h014;

    ////////////////////////////////////////////////////////////////////////
    // Watchdog control register field positions
    localparam int WDT_ENABLE_POS = 5;
    localparam int WDT_CLEAR_POS = 4;
    localparam int WDT_IDLE_POS = 3;
    localparam int WDT_PS_LSB = 0;
    localparam logic [5:0] WDT_MASK_ALL = 6'h3f;
    localparam logic [5:0] WDT_MASK_CLEAR = 6'h10;
    localparam logic [5:0] WDT_MASK_CLEAR_PS = 6'h17;
    localparam logic [5:0] WDT_RESET = 6'h00;

    ////////////////////////////////////////////////////////////////////////
    // Flash geometry and option encodings
    localparam logic [13:0] FLASH_END = 14'h3fff;
    localparam logic [14:0] FLASH_LIMIT = 15'h4000;
    localparam logic [13:0] ISP_BASE = 14'h3000;
    localparam logic [13:0] ISP_STEP = 14'h0200;
    localparam logic [2:0] ISP_OFF_CODE = 3'h7;
    localparam logic [4:0] IAP_OFF_CODE = 5'h1f;
    localparam int PAGE_SHIFT = 9;
    localparam logic [13:0] AP_ENTRY = 14'h0000;
    localparam logic [17:0] OPTION_ERASED = 18'h3ffff;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int NV_READ_NS = 40;
    localparam int NV_READ_CYCLES =
        (NV_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // Stored option word: a set flag bit means disabled (erased state)
    typedef struct packed {
        logic [4:0] iap_size;
        logic [2:0] isp_size;
        logic boot_select_option_n;
        logic reset_boot_select_option_n;
        logic scramble_option_n;
        logic lock_option_n;
        logic watchdog_write_protect_option_n;
        logic watchdog_auto_enable_option_n;
        logic idle_count_preset;
        logic [2:0] prescaler_preset;
    } option_type;

    // Flash region map handed to the flash controller
    typedef struct packed {
        logic isp_on;
        logic [13:0] isp_start;
        logic iap_on;
        logic [13:0] iap_low;
        logic [13:0] iap_high;
    } region_type;

    typedef enum {
        ST_LOAD,
        ST_APPLY,
        ST_RUN,
        ST_EXT
    } loader_state_type;

endpackage

// >>> verification/option_writer.sv
// Partner model: option storage as set by an external writer, readout beats
`timescale 1ns/10ps
`default_nettype none

module option_writer
    import boot_option_pkg::*;
(
    // Clock and option storage
    input wire logic pclk,
    input wire logic nv_read_en,
    output logic [17:0] nv_option,
    // Writer mode pin and readout beat
    output logic prog_mode_pin,
    output logic flash_rvalid,
    output logic [13:0] flash_raddr,
    output logic [7:0] flash_rdata
);
    option_type stored = OPTION_ERASED;

    // Word is only valid while read; junk otherwise catches late sampling
    assign nv_option = nv_read_en ? stored : ~stored;

    initial begin
        prog_mode_pin = 1'b0;
        flash_rvalid = 1'b0;
        flash_raddr = 14'h0000;
        flash_rdata = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Only the writer changes the stored options
    task automatic burn(input option_type w);
        stored = w;
    endtask

    // Writer mode pin belongs to the writer, never driven by the bench
    task automatic set_mode(input logic m);
        prog_mode_pin <= m;
    endtask

    task automatic dump(input logic [13:0] a, input logic [7:0] d);
        @(posedge pclk);
        flash_rvalid <= 1'b1;
        flash_raddr <= a;
        flash_rdata <= d;
        @(posedge pclk);
        flash_rvalid <= 1'b0;
        flash_raddr <= ~a;
        flash_rdata <= ~d;
    endtask
endmodule

`default_nettype wire

// >>> verification/boot_option_loader_test.sv
// Self-checking testbench of the boot option loader
`timescale 1ns/10ps
`default_nettype none

module boot_option_loader_test
    import boot_option_pkg::*;
;
    localparam logic [7:0] KEY = 8'h5a;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nv_read_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [17:0] nv_option;
    logic ext_reset_pin, prog_mode_pin, cpu_in_isp, cpu_reset_n;
    logic boot_from_isp, wd_en, wd_idle, wd_clr, flash_rvalid, prog_dvalid;
    logic code_lock, re;
    logic [13:0] boot_addr, flash_raddr;
    logic [2:0] wd_ps;
    logic [7:0] flash_rdata, prog_dout;
    region_type region;
    int n_fail = 0;
    int total_checks = 0;

    boot_option_loader #(.SCRAMBLE_KEY(KEY)) uut (
        .pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .nv_read_en(nv_read_en), .nv_option(nv_option),
        .ext_reset_pin(ext_reset_pin), .prog_mode_pin(prog_mode_pin),
        .cpu_in_isp(cpu_in_isp), .cpu_reset_n(cpu_reset_n),
        .boot_from_isp(boot_from_isp), .boot_addr(boot_addr),
        .region(region), .watchdog_enable_bit(wd_en),
        .watchdog_idle_count_bit(wd_idle), .watchdog_prescaler_field(wd_ps),
        .watchdog_clear_bit(wd_clr), .flash_rvalid(flash_rvalid),
        .flash_raddr(flash_raddr), .flash_rdata(flash_rdata),
        .prog_dvalid(prog_dvalid), .prog_dout(prog_dout),
        .code_lock(code_lock)
    );

    option_writer writer (
        .pclk(pclk), .nv_read_en(nv_read_en), .nv_option(nv_option),
        .prog_mode_pin(prog_mode_pin), .flash_rvalid(flash_rvalid),
        .flash_raddr(flash_raddr), .flash_rdata(flash_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // en = {boot, reset boot, scramble, lock, protect, auto}, wd = idle,ps
    function automatic option_type mk(input logic [2:0] isp,
        input logic [4:0] iap, input logic [5:0] en, input logic [3:0] wd);
        return {iap, isp, ~en, wd};
    endfunction

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_fail++;
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Pin-reset path has a sync, a reload and an apply: allow ample time
    task automatic wait_run();
        int n;
        n = 0;
        while (cpu_reset_n !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 100) n_fail++;
        repeat (2) @(posedge pclk);
    endtask

    task automatic power_up(input option_type w);
        writer.burn(w);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        wait_run();
    endtask

    task automatic pin_reset();
        int n;
        @(posedge pclk);
        ext_reset_pin <= 1'b1;
        n = 0;
        while (cpu_reset_n !== 1'b0 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20) n_fail++;
        ext_reset_pin <= 1'b0;
        @(posedge pclk);
        wait_run();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_erased();
        power_up(OPTION_ERASED);
        chk({region.isp_on, region.iap_on, boot_from_isp}, 0);
        chk(boot_addr, AP_ENTRY);
        apb(1'b1, OFS_OPTION, 32'h0);
        apb(1'b0, OFS_OPTION, 32'h0);
        chk(rv, 32'h3ffff);
        apb(1'b0, OFS_BOOT, 32'h0);
        chk(rv, 32'h3c);
        apb(1'b0, 12'h018, 32'h0);
        chk({re, rv}, {1'b1, 32'h0});
        $display("test erased done");
    endtask

    task automatic t_region();
        logic [2:0] isp;
        logic [4:0] iap;
        logic [14:0] top;
        logic [13:0] st;
        for (int i = 0; i < 10; i++) begin
            isp = (i < 8) ? 3'(i) : 3'h7;
            iap = (i == 8) ? 5'h00 : ((i == 9) ? 5'h1f : 5'h1d);
            st = 14'h3000 + {isp, 9'h000};
            top = (isp != 3'h7) ? {1'b0, st} : 15'h4000;
            power_up(mk(isp, iap, 6'h00, 4'h0));
            chk(region.isp_on, isp != 3'h7);
            chk(region.isp_start, (isp != 3'h7) ? st : FLASH_END);
            chk(region.iap_on, iap != 5'h1f);
            if (iap != 5'h1f) begin
                chk(region.iap_low, top - {5'h1f - iap, 9'h000});
                chk(region.iap_high, top - 15'h1);
            end
        end
        $display("test region done");
    endtask

    task automatic t_boot(input logic [2:0] isp, input logic bs,
                          input logic rbs, input logic pw, input logic pin);
        logic [13:0] st;
        st = 14'h3000 + {isp, 9'h000};
        power_up(mk(isp, 5'h1f, {bs, rbs, 4'h0}, 4'h0));
        chk(boot_from_isp, pw);
        chk(boot_addr, pw ? st : AP_ENTRY);
        pin_reset();
        chk(boot_from_isp, pin);
        chk(boot_addr, pin ? st : AP_ENTRY);
        $display("test boot done");
    endtask

    task automatic t_wdt();
        power_up(mk(3'h1, 5'h1f, 6'h03, 4'hd));
        apb(1'b0, OFS_WDT, 32'h0);
        chk(rv, 32'h2d);
        cpu_in_isp <= 1'b1;
        apb(1'b1, OFS_WDT, 32'h0);
        apb(1'b0, OFS_WDT, 32'h0);
        chk(rv, 32'h28);
        apb(1'b1, OFS_WDT, 32'h37);
        #1 chk(wd_clr, 1'b1);
        apb(1'b0, OFS_WDT, 32'h0);
        chk(rv, 32'h2f);
        cpu_in_isp <= 1'b0;
        apb(1'b1, OFS_WDT, 32'h10);
        #1 chk(wd_clr, 1'b1);
        apb(1'b1, OFS_WDT, 32'h00);
        apb(1'b0, OFS_WDT, 32'h0);
        chk(rv, 32'h2f);
        power_up(mk(3'h1, 5'h1f, 6'h00, 4'hd));
        chk({wd_en, wd_idle, wd_ps}, 5'h00);
        apb(1'b1, OFS_WDT, 32'h3f);
        #1 chk(wd_clr, 1'b1);
        apb(1'b0, OFS_WDT, 32'h0);
        chk(rv, 32'h2f);
        $display("test watchdog done");
    endtask

    task automatic t_dump(input logic sb, input logic lk);
        logic [7:0] exp_dout;
        exp_dout = lk ? 8'h00 : (sb ? 8'ha5 ^ 8'h23 ^ KEY : 8'ha5);
        power_up(mk(3'h7, 5'h1f, {2'b00, sb, lk, 2'b00}, 4'h0));
        writer.set_mode(1'b1);
        repeat (4) @(posedge pclk);
        writer.dump(14'h0123, 8'ha5);
        #1 chk(prog_dvalid, 1'b1);
        chk(prog_dout, exp_dout);
        chk(code_lock, lk);
        writer.set_mode(1'b0);
        $display("test readout done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Run control
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial begin
        #40000;
        n_fail++;
        test_done();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ext_reset_pin = 1'b0;
        cpu_in_isp = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_erased();
        t_region();
        t_boot(3'h2, 1'b1, 1'b0, 1'b1, 1'b1);
        t_boot(3'h2, 1'b0, 1'b0, 1'b0, 1'b0);
        t_boot(3'h6, 1'b0, 1'b1, 1'b0, 1'b1);
        t_boot(3'h7, 1'b1, 1'b1, 1'b0, 1'b0);
        t_wdt();
        t_dump(1'b0, 1'b0);
        t_dump(1'b1, 1'b0);
        t_dump(1'b1, 1'b1);
        test_done();
    end
endmodule

`default_nettype wire
